//--- src/etc_pkg.sv
package etc_pkg;

  // ----------------------------------------
  // Field positions within the five-bit control word
  // ----------------------------------------
  localparam int FLD_WAIT_POS = 0;
  localparam int FLD_ORDER_POS = 1;
  localparam int FLD_ERR_POS = 2;
  localparam int FLD_KEY_POS = 3;
  localparam int FLD_PA_POS = 4;
  localparam int FLD_WIDTH = 5;
  localparam int FLD_LSB_IN_REG = 13;

  // Warm reset gives an unknown value; this pattern stands in for it.
  localparam logic [4:0] FLD_RESET_VAL = 5'h00;

  // ----------------------------------------
  // Syndrome classes and levels
  // ----------------------------------------
  localparam logic [5:0] CLASS_NONE = 6'h00;
  localparam logic [5:0] CLASS_WAIT = 6'h01;
  localparam logic [5:0] CLASS_COPROC32 = 6'h03;
  localparam logic [5:0] CLASS_PTR_AUTH = 6'h09;
  localparam logic [5:0] CLASS_SYSREG = 6'h18;
  localparam logic [1:0] LEVEL_TOP = 2'h3;

  // ----------------------------------------
  // Request kinds
  // ----------------------------------------
  typedef enum logic [2:0] {
    KIND_PA_INSTR,
    KIND_GEN_AUTH,
    KIND_KEY_REG,
    KIND_ERR_REG,
    KIND_ORDER_REG,
    KIND_WAIT,
    KIND_TIMED_WAIT
  } etc_kind_t;

  typedef enum logic [1:0] {
    ERR_BASE,
    ERR_SECOND,
    ERR_MISC23,
    ERR_MISC47
  } etc_err_grp_t;

endpackage

//--- src/etc_trap_field.sv
module etc_trap_field #(
  parameter bit IMPLEMENTED = 1'b1,
  parameter bit RESET_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic wr_bit,
  output logic value
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      value <= IMPLEMENTED ? RESET_VAL : 1'b0;
    end else if (wr_en && IMPLEMENTED) begin
      value <= wr_bit;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_unimpl_zero: assert property (@(posedge clk) disable iff (rst)
    !IMPLEMENTED |-> !value) else $error("unimplemented field not zero");

endmodule

//--- src/etc_pa_enable_sel.sv
module etc_pa_enable_sel #(
  parameter bit SECURE_HYP = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] level,
  input wire logic secure,
  input wire logic trap_general_exceptions,
  input wire logic e2h,
  input wire logic l1_en,
  input wire logic l2_en,
  output logic en
);

  logic host_mode;

  // ----------------------------------------
  // Enable selection
  // ----------------------------------------
  always_comb begin
    host_mode = trap_general_exceptions && e2h && (SECURE_HYP || !secure);
    en = 1'b0;
    unique case (level)
      2'h0: en = host_mode ? l2_en : l1_en;
      2'h1: en = l1_en;
      2'h2: en = l2_en;
      2'h3: en = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_level_two_src: assert property (@(posedge clk) disable iff (rst)
    level == 2'h2 |-> en == l2_en) else $error("level 2 enable source wrong");
  a_sec_zero_src: assert property (@(posedge clk) disable iff (rst)
    (!SECURE_HYP && secure && level == 2'h0) |-> en == l1_en)
    else $error("secure level 0 enable source wrong");

endmodule

//--- src/etc_top.sv
module etc_top #(
  parameter bit TOP_LEVEL_PRESENT = 1'b1,
  parameter bit SECURE_HYP_SUPPORT = 1'b1,
  parameter bit POINTER_AUTH_SUPPORT = 1'b1,
  parameter bit RELIABILITY_SUPPORT = 1'b1,
  parameter bit RELIABILITY_EXT_SUPPORT = 1'b1,
  parameter bit ORDERING_REGION_SUPPORT = 1'b1,
  parameter bit TIMED_WAIT_SUPPORT = 1'b1
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CTRL_WR_EN,
  input wire logic [4:0] CTRL_WR_DATA,
  output logic [4:0] CTRL_RD_DATA,
  output logic CTRL_INIT,
  input wire logic REQ_VALID,
  input wire etc_pkg::etc_kind_t REQ_KIND,
  input wire logic [1:0] REQ_LEVEL,
  input wire logic REQ_SECURE,
  input wire logic REQ_STATE32,
  input wire logic REQ_COND_PASS,
  input wire logic REQ_DEFINED,
  input wire etc_pkg::etc_err_grp_t REQ_ERR_GRP,
  input wire logic LEVEL1_KEY_EN,
  input wire logic LEVEL2_KEY_EN,
  input wire logic TRAP_GENERAL_EXCEPTIONS,
  input wire logic HOST_EXTENSION_ENABLE,
  input wire logic HYP_PTR_AUTH_TRAP,
  input wire logic HYP_KEY_TRAP,
  input wire logic OTHER_KEY_TRAP,
  input wire logic HYP_REGION_TRAP,
  input wire logic LOWER_WAIT_TRAP,
  input wire logic WOULD_SLEEP,
  output logic TRAP_VALID,
  output logic TRAP_TAKEN,
  output logic [5:0] TRAP_CLASS
);

  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  localparam bit [4:0] FLD_IMPL = {POINTER_AUTH_SUPPORT, POINTER_AUTH_SUPPORT,
                                   RELIABILITY_SUPPORT, ORDERING_REGION_SUPPORT, 1'b1};

  logic [4:0] field_q;
  logic ptr_auth_instr_trap_n;
  logic auth_key_reg_trap_n;
  logic error_record_trap;
  logic ordering_region_trap;
  logic wait_event_trap;
  logic key_en_sel;
  logic below_top;
  logic mid_level;
  logic err_covered;
  logic wait_ok;
  logic trap_next;
  logic [5:0] class_next;
  logic init_reg;

  genvar gi;
  generate
    for (gi = 0; gi < etc_pkg::FLD_WIDTH; gi++) begin : g_field
      etc_trap_field #(
        .IMPLEMENTED(FLD_IMPL[gi]),
        .RESET_VAL(etc_pkg::FLD_RESET_VAL[gi])
      ) u_field (
        .clk(CLK),
        .rst(SYS_RST),
        .wr_en(CTRL_WR_EN),
        .wr_bit(CTRL_WR_DATA[gi]),
        .value(field_q[gi])
      );
    end
  endgenerate

  assign CTRL_RD_DATA = field_q;
  assign CTRL_INIT = init_reg;

  // Fields hold the FLD_RESET_VAL stand-in from reset until software has written them once.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      init_reg <= 1'b0;
    end else if (CTRL_WR_EN) begin
      init_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // Effective field values
  // ----------------------------------------
  always_comb begin
    ptr_auth_instr_trap_n = field_q[etc_pkg::FLD_PA_POS] || !TOP_LEVEL_PRESENT;
    auth_key_reg_trap_n = field_q[etc_pkg::FLD_KEY_POS] || !TOP_LEVEL_PRESENT;
    error_record_trap = field_q[etc_pkg::FLD_ERR_POS];
    ordering_region_trap = field_q[etc_pkg::FLD_ORDER_POS];
    wait_event_trap = field_q[etc_pkg::FLD_WAIT_POS];
  end

  etc_pa_enable_sel #(
    .SECURE_HYP(SECURE_HYP_SUPPORT)
  ) u_pa_en (
    .clk(CLK),
    .rst(SYS_RST),
    .level(REQ_LEVEL),
    .secure(REQ_SECURE),
    .trap_general_exceptions(TRAP_GENERAL_EXCEPTIONS),
    .e2h(HOST_EXTENSION_ENABLE),
    .l1_en(LEVEL1_KEY_EN),
    .l2_en(LEVEL2_KEY_EN),
    .en(key_en_sel)
  );

  // ----------------------------------------
  // Trap decision
  // ----------------------------------------
  always_comb begin
    below_top = REQ_LEVEL != etc_pkg::LEVEL_TOP;
    mid_level = (REQ_LEVEL == 2'h1) || (REQ_LEVEL == 2'h2);
    unique case (REQ_ERR_GRP)
      etc_pkg::ERR_BASE: err_covered = 1'b1;
      etc_pkg::ERR_SECOND: err_covered = REQ_STATE32;
      etc_pkg::ERR_MISC23: err_covered = REQ_STATE32 || RELIABILITY_EXT_SUPPORT;
      etc_pkg::ERR_MISC47: err_covered = REQ_STATE32 && RELIABILITY_EXT_SUPPORT;
    endcase
    wait_ok = wait_event_trap && below_top && !LOWER_WAIT_TRAP
              && (!REQ_STATE32 || REQ_COND_PASS);
    trap_next = 1'b0;
    class_next = etc_pkg::CLASS_NONE;
    unique case (REQ_KIND)
      etc_pkg::KIND_PA_INSTR: begin
        trap_next = POINTER_AUTH_SUPPORT && !ptr_auth_instr_trap_n && below_top
                    && key_en_sel && !HYP_PTR_AUTH_TRAP;
        class_next = etc_pkg::CLASS_PTR_AUTH;
      end
      etc_pkg::KIND_GEN_AUTH: begin
        trap_next = POINTER_AUTH_SUPPORT && !SECURE_HYP_SUPPORT && !ptr_auth_instr_trap_n
                    && below_top && !HYP_PTR_AUTH_TRAP;
        class_next = etc_pkg::CLASS_PTR_AUTH;
      end
      etc_pkg::KIND_KEY_REG: begin
        trap_next = POINTER_AUTH_SUPPORT && !auth_key_reg_trap_n && mid_level
                    && !HYP_KEY_TRAP && !OTHER_KEY_TRAP;
        class_next = etc_pkg::CLASS_SYSREG;
      end
      etc_pkg::KIND_ERR_REG: begin
        trap_next = RELIABILITY_SUPPORT && error_record_trap && mid_level && err_covered;
        class_next = REQ_STATE32 ? etc_pkg::CLASS_COPROC32 : etc_pkg::CLASS_SYSREG;
      end
      etc_pkg::KIND_ORDER_REG: begin
        trap_next = ORDERING_REGION_SUPPORT && ordering_region_trap && mid_level
                    && REQ_DEFINED && !HYP_REGION_TRAP;
        class_next = etc_pkg::CLASS_SYSREG;
      end
      etc_pkg::KIND_WAIT: begin
        trap_next = wait_ok && WOULD_SLEEP;
        class_next = etc_pkg::CLASS_WAIT;
      end
      etc_pkg::KIND_TIMED_WAIT: begin
        trap_next = TIMED_WAIT_SUPPORT && wait_ok && WOULD_SLEEP;
        class_next = etc_pkg::CLASS_WAIT;
      end
      default: begin
        trap_next = 1'b0;
        class_next = etc_pkg::CLASS_NONE;
      end
    endcase
    if (!REQ_VALID || !trap_next) begin
      trap_next = 1'b0;
      class_next = etc_pkg::CLASS_NONE;
    end
  end

  // ----------------------------------------
  // Answer registers
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      TRAP_VALID <= 1'b0;
      TRAP_TAKEN <= 1'b0;
      TRAP_CLASS <= etc_pkg::CLASS_NONE;
    end else begin
      TRAP_VALID <= REQ_VALID;
      TRAP_TAKEN <= trap_next;
      TRAP_CLASS <= class_next;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  a_pa_open_bit: assert property (
    REQ_VALID && REQ_KIND == etc_pkg::KIND_PA_INSTR && field_q[etc_pkg::FLD_PA_POS]
    |=> !TRAP_TAKEN) else $error("pointer-auth trapped while bit set");
  a_pa_class_code: assert property (
    REQ_VALID && REQ_KIND == etc_pkg::KIND_PA_INSTR ##1 TRAP_TAKEN
    |-> TRAP_CLASS == 6'h09) else $error("pointer-auth class wrong");
  a_gen_auth_free: assert property (
    SECURE_HYP_SUPPORT && REQ_VALID && REQ_KIND == etc_pkg::KIND_GEN_AUTH
    |=> !TRAP_TAKEN) else $error("generic auth trapped");
  a_pa_key_off: assert property (
    REQ_VALID && REQ_KIND == etc_pkg::KIND_PA_INSTR && !key_en_sel
    |=> !TRAP_TAKEN) else $error("disabled pointer-auth trapped");
  a_no_top_level: assert property (
    !TOP_LEVEL_PRESENT && REQ_VALID && REQ_KIND inside {etc_pkg::KIND_PA_INSTR,
    etc_pkg::KIND_KEY_REG} |=> !TRAP_TAKEN) else $error("trap without top level");
  a_key_reg_trap: assert property (
    POINTER_AUTH_SUPPORT && TOP_LEVEL_PRESENT && REQ_VALID
    && REQ_KIND == etc_pkg::KIND_KEY_REG && REQ_LEVEL == 2'h1
    && !field_q[etc_pkg::FLD_KEY_POS] && !HYP_KEY_TRAP && !OTHER_KEY_TRAP
    |=> TRAP_TAKEN && TRAP_CLASS == 6'h18) else $error("key register trap missed");
  a_err_class32: assert property (
    REQ_VALID && REQ_KIND == etc_pkg::KIND_ERR_REG && REQ_STATE32 ##1 TRAP_TAKEN
    |-> TRAP_CLASS == 6'h03) else $error("32-bit error record class wrong");
  a_region_hyp: assert property (
    REQ_VALID && REQ_KIND == etc_pkg::KIND_ORDER_REG && HYP_REGION_TRAP
    |=> !TRAP_TAKEN) else $error("region trap overrode hypervisor");
  a_wait_cond_fail: assert property (
    REQ_VALID && REQ_KIND == etc_pkg::KIND_WAIT && REQ_STATE32 && !REQ_COND_PASS
    |=> !TRAP_TAKEN) else $error("failed-condition wait trapped");
  a_wait_sleep_trap: assert property (
    REQ_VALID && REQ_KIND == etc_pkg::KIND_WAIT && wait_event_trap && WOULD_SLEEP
    && REQ_LEVEL != 2'h3 && !LOWER_WAIT_TRAP && !REQ_STATE32
    |=> TRAP_TAKEN && TRAP_CLASS == 6'h01) else $error("sleeping wait not trapped");
  a_answer_pulse: assert property (
    TRAP_TAKEN |-> TRAP_VALID && $past(REQ_VALID)) else $error("trap without request");

  c_pa_trap: cover property (TRAP_TAKEN && TRAP_CLASS == 6'h09);
  c_err_trap32: cover property (TRAP_TAKEN && TRAP_CLASS == 6'h03);
  c_wait_trap: cover property (TRAP_TAKEN && TRAP_CLASS == 6'h01);

endmodule

//--- dv/etc_ctl_model.sv
// ----------------------------------------
// Lower-level controls seen by the trap logic
// ----------------------------------------
module etc_ctl_model (
  output logic l1_en,
  output logic l2_en,
  output logic trap_general_exceptions,
  output logic e2h,
  output logic hyp_pa,
  output logic hyp_key,
  output logic oth_key,
  output logic hyp_reg,
  output logic low_wait,
  output logic sleep
);
  timeunit 1ns;
  timeprecision 1ps;

  // Lower-level traps fire only now and then, so top-level traps stay visible.
  function automatic logic rare();
    return ($urandom_range(3) == 0);
  endfunction

  initial begin
    {l1_en, l2_en, trap_general_exceptions, e2h, hyp_pa, hyp_key, oth_key, hyp_reg, low_wait, sleep} = 10'h000;
  end

  task automatic shuffle();
    {l1_en, l2_en, trap_general_exceptions, e2h} = 4'($urandom_range(15));
    hyp_pa = rare();
    hyp_key = rare();
    oth_key = rare();
    hyp_reg = rare();
    low_wait = rare();
    sleep = !rare();
  endtask
endmodule

//--- dv/el3_trap_control_bits_tb.sv
module el3_trap_control_bits_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr_en = 1'b0;
  logic [4:0] wr_data = 5'h00;
  logic [4:0] rd_data;
  logic init;
  logic req_valid = 1'b0;
  etc_pkg::etc_kind_t kind = etc_pkg::KIND_WAIT;
  etc_pkg::etc_err_grp_t grp = etc_pkg::ERR_BASE;
  logic [1:0] lvl = 2'h0;
  logic sec = 1'b0, s32 = 1'b0, cond = 1'b0, def = 1'b0;
  logic l1, l2, trap_general_exceptions, e2h, hpa, hk, ok, hr, lw, sl;
  logic valid, taken;
  logic [5:0] cls;
  logic [6:0] expq[$];
  logic [4:0] fld = 5'h00;
  logic known = 1'b0;
  int n_errors = 0;
  int total_checks = 0;

  always #2.5 clk = ~clk;

  etc_ctl_model src (.l1_en(l1), .l2_en(l2), .trap_general_exceptions(trap_general_exceptions), .e2h(e2h), .hyp_pa(hpa),
    .hyp_key(hk), .oth_key(ok), .hyp_reg(hr), .low_wait(lw), .sleep(sl));

  etc_top uut (.CLK(clk), .SYS_RST(rst), .CTRL_WR_EN(wr_en), .CTRL_WR_DATA(wr_data),
    .CTRL_RD_DATA(rd_data), .CTRL_INIT(init), .REQ_VALID(req_valid), .REQ_KIND(kind),
    .REQ_LEVEL(lvl), .REQ_SECURE(sec), .REQ_STATE32(s32), .REQ_COND_PASS(cond),
    .REQ_DEFINED(def), .REQ_ERR_GRP(grp), .LEVEL1_KEY_EN(l1), .LEVEL2_KEY_EN(l2),
    .TRAP_GENERAL_EXCEPTIONS(trap_general_exceptions), .HOST_EXTENSION_ENABLE(e2h), .HYP_PTR_AUTH_TRAP(hpa),
    .HYP_KEY_TRAP(hk), .OTHER_KEY_TRAP(ok), .HYP_REGION_TRAP(hr), .LOWER_WAIT_TRAP(lw),
    .WOULD_SLEEP(sl), .TRAP_VALID(valid), .TRAP_TAKEN(taken), .TRAP_CLASS(cls));

  // Returns {taken, class} for the request now on the inputs, all features present.
  function automatic logic [6:0] expect_trap(input logic [4:0] f);
    logic en;
    logic mid;
    logic cov;
    en = (lvl == 2'h2 || (lvl == 2'h0 && trap_general_exceptions && e2h)) ? l2 : l1;
    mid = (lvl == 2'h1 || lvl == 2'h2);
    cov = (grp == etc_pkg::ERR_BASE || grp == etc_pkg::ERR_MISC23 || s32);
    if (lvl == 2'h3) return 7'h00;
    case (kind)
      etc_pkg::KIND_PA_INSTR: return (!f[4] && en && !hpa) ? 7'h49 : 7'h00;
      etc_pkg::KIND_KEY_REG: return (!f[3] && mid && !hk && !ok) ? 7'h58 : 7'h00;
      etc_pkg::KIND_ERR_REG: return (f[2] && mid && cov) ? (s32 ? 7'h43 : 7'h58) : 7'h00;
      etc_pkg::KIND_ORDER_REG: return (f[1] && mid && def && !hr) ? 7'h58 : 7'h00;
      etc_pkg::KIND_WAIT, etc_pkg::KIND_TIMED_WAIT:
        return (f[0] && sl && !lw && (!s32 || cond)) ? 7'h41 : 7'h00;
      default: return 7'h00;
    endcase
  endfunction

  task automatic chk(input string what, input logic [6:0] e, input logic [6:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // One falling-edge step: check control state, then drive a new request and write.
  task automatic step(input logic v, input logic w, input logic [4:0] d);
    @(negedge clk);
    if (known) chk("ctrl_rd", {2'h0, fld}, {2'h0, rd_data});
    chk("ctrl_init", {6'h00, known}, {6'h00, init});
    src.shuffle();
    kind = etc_pkg::etc_kind_t'($urandom_range(6));
    lvl = 2'($urandom_range(3));
    {sec, s32, cond, def} = 4'($urandom_range(15));
    grp = etc_pkg::etc_err_grp_t'($urandom_range(3));
    req_valid = v;
    wr_en = w;
    wr_data = d;
    if (v) expq.push_back(expect_trap(fld));
    if (w) begin
      fld = d;
      known = 1'b1;
    end
  endtask

  task automatic do_reset();
    @(negedge clk);
    rst = 1'b1;
    req_valid = 1'b0;
    wr_en = 1'b0;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    known = 1'b0;
    expq.delete();
  endtask

  // ----------------------------------------
  // Result monitor
  // ----------------------------------------
  always @(posedge clk) begin
    #1;
    if (valid === 1'b1 && expq.size() == 0) begin
      chk("trap_valid", 7'h00, 7'h7f);
    end else if (expq.size() > 0) begin
      chk("trap_valid", 7'h01, {6'h00, valid});
      chk("trap", expq.pop_front(), {taken, cls});
    end
  end

  initial begin
    #20000;
    n_errors++;
    stop_test();
  end

  initial begin
    void'($urandom(48266));
    repeat (3) @(negedge clk);
    rst = 1'b0;
    for (int p = 0; p < 2; p++) begin
      step(1'b0, 1'b0, 5'h00);
      step(1'b0, 1'b1, 5'($urandom_range(31)));
      for (int i = 0; i < 400; i++) begin
        step(1'b1, ($urandom_range(7) == 0), 5'($urandom_range(31)));
      end
      do_reset();
    end
    step(1'b0, 1'b0, 5'h00);
    repeat (2) @(negedge clk);
    stop_test();
  end
endmodule
